// ===== hdl/qlt_scan.sv
// Line enables, scanner, modem control, break and interrupt requests.
// Assumes same-clock UARTs and silo logic; ring and carrier are pins.
`timescale 1ns/10ps
module qlt_scan (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Register port
    input wire logic [1:0] i_reg_sel,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [1:0] i_reg_be,
    input wire logic [15:0] i_reg_wdata,
    output logic [15:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Control and status bits
    input wire logic i_master_scan_enable,
    input wire logic i_tx_irq_enable,
    input wire logic i_rx_irq_enable,
    input wire logic i_silo_alarm_enable,
    input wire logic i_master_clear,
    input wire logic i_bus_init,
    output logic o_tx_ready_flag,
    output logic [1:0] o_tx_line_number,
    output logic o_silo_alarm_flag,
    // Receive silo events
    input wire logic i_rx_done_flag,
    input wire logic i_silo_char_in,
    input wire logic i_rx_buffer_access,
    // Interrupt requests
    output logic o_rx_irq_req,
    output logic o_tx_irq_req,
    output logic [2:0] o_irq_vector,
    // Line transmitters
    input wire logic [qlt_pkg::LINES-1:0] i_line_tx_empty,
    output logic o_char_valid,
    output logic [qlt_pkg::CHAR_W-1:0] o_char_data,
    output logic [1:0] o_char_line,
    input wire logic i_char_ready,
    input wire logic [qlt_pkg::LINES-1:0] i_uart_txd,
    output logic [qlt_pkg::LINES-1:0] o_line_txd,
    // Modem lines
    input wire logic [qlt_pkg::LINES-1:0] i_ring,
    input wire logic [qlt_pkg::LINES-1:0] i_carrier,
    output logic [qlt_pkg::LINES-1:0] o_term_ready
);
    import qlt_pkg::*;

    localparam int BW = CHAR_W + 2;

    qlt_scan_type state_reg;
    logic [LINES-1:0] line_enable_reg;
    logic [LINES-1:0] break_reg;
    logic [LINES-1:0] pending_reg;
    logic [LINES-1:0] ring_meta_reg;
    logic [LINES-1:0] ring_reg;
    logic [LINES-1:0] carrier_meta_reg;
    logic [LINES-1:0] carrier_reg;
    logic [4:0] silo_cnt_reg;
    logic [4:0] silo_cnt_next;
    logic clear_any;
    logic ctrl_wr;
    logic char_wr;
    logic brk_wr;
    logic buf_in_ready;
    logic [BW-1:0] buf_out;
    logic [LINES-1:0] cand;
    logic [1:0] pick;
    logic start;
    logic pop;

    function automatic logic [1:0] top_line(input logic [LINES-1:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < LINES; i++) begin
            if (v[i]) begin
                r = i[1:0];
            end
        end
        return r;
    endfunction : top_line

    assign clear_any = i_bus_init || i_master_clear;
    assign ctrl_wr = i_reg_wr && i_reg_sel == REG_TX_LINE_CTRL;
    assign char_wr = i_reg_wr && i_reg_sel == REG_TX_CHAR_BREAK
        && i_reg_be[0];
    assign brk_wr = i_reg_wr && i_reg_sel == REG_TX_CHAR_BREAK
        && i_reg_be[1];
    // Lines with a free transmitter not already fed a character
    assign cand = line_enable_reg & i_line_tx_empty & ~pending_reg;
    assign pick = top_line(cand);
    assign start = i_master_scan_enable && (|cand) && buf_in_ready;
    assign pop = o_char_valid && i_char_ready;
    assign o_char_data = buf_out[CHAR_W-1:0];
    assign o_char_line = buf_out[BW-1:CHAR_W];

    // Characters wait here until their line transmitter takes them
    qlt_buf #(.WIDTH(BW), .DEPTH(BUF_DEPTH)) u_buf (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(char_wr),
        .i_in_data({o_tx_line_number, i_reg_wdata[CHAR_LSB +: CHAR_W]}),
        .o_in_ready(buf_in_ready),
        .o_out_valid(o_char_valid),
        .o_out_data(buf_out),
        .i_out_ready(i_char_ready)
    );

    // Line enables
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            line_enable_reg <= ENABLE_RST;
        end else if (i_ce) begin
            if (clear_any) begin
                line_enable_reg <= ENABLE_RST;
            end else if (ctrl_wr && i_reg_be[0]) begin
                line_enable_reg <= i_reg_wdata[ENABLE_LSB +: LINES];
            end
        end
    end

    // Terminal ready, untouched by master clear
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_term_ready <= DTR_RST;
        end else if (i_ce) begin
            if (i_bus_init) begin
                o_term_ready <= DTR_RST;
            end else if (ctrl_wr && i_reg_be[1]) begin
                o_term_ready <= i_reg_wdata[DTR_LSB +: LINES];
            end
        end
    end

    // Break bits and serial outputs
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            break_reg <= BREAK_RST;
            o_line_txd <= {LINES{MARK_LEVEL}};
        end else if (i_ce) begin
            if (clear_any) begin
                break_reg <= BREAK_RST;
            end else if (brk_wr) begin
                break_reg <= i_reg_wdata[BREAK_LSB +: LINES];
            end
            for (int i = 0; i < LINES; i++) begin
                o_line_txd[i] <= break_reg[i] ? SPACE_LEVEL : i_uart_txd[i];
            end
        end
    end

    // Lines holding a buffered character; a new push wins
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pending_reg <= '0;
        end else if (i_ce) begin
            for (int i = 0; i < LINES; i++) begin
                if (char_wr && buf_in_ready && o_tx_line_number == i[1:0]) begin
                    pending_reg[i] <= 1'b1;
                end else if (pop && o_char_line == i[1:0]) begin
                    pending_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Scanner
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= QLT_SCAN;
            o_tx_ready_flag <= 1'b0;
            o_tx_line_number <= LINE_RST;
        end else if (i_ce) begin
            if (clear_any) begin
                state_reg <= QLT_SCAN;
                o_tx_ready_flag <= 1'b0;
            end else begin
                case (state_reg)
                    QLT_SCAN: begin
                        if (start) begin
                            state_reg <= QLT_HALT;
                            o_tx_line_number <= pick;
                            o_tx_ready_flag <= 1'b1;
                        end
                    end
                    QLT_HALT: begin
                        if (!i_master_scan_enable || char_wr
                                || !line_enable_reg[o_tx_line_number]) begin
                            state_reg <= QLT_SCAN;
                            o_tx_ready_flag <= 1'b0;
                        end
                    end
                    default: begin
                        state_reg <= QLT_SCAN;
                        o_tx_ready_flag <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Silo alarm counter; a character in the access cycle still counts
    always_comb begin
        silo_cnt_next = silo_cnt_reg;
        if (i_rx_buffer_access) begin
            silo_cnt_next = i_silo_char_in ? 5'h01 : SILO_CNT_RST;
        end else if (i_silo_char_in && silo_cnt_reg != SILO_ALARM_COUNT) begin
            silo_cnt_next = silo_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            silo_cnt_reg <= SILO_CNT_RST;
            o_silo_alarm_flag <= 1'b0;
        end else if (i_ce) begin
            silo_cnt_reg <= silo_cnt_next;
            o_silo_alarm_flag <= silo_cnt_next == SILO_ALARM_COUNT;
        end
    end

    // Interrupt requests and vector
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_irq_req <= 1'b0;
            o_tx_irq_req <= 1'b0;
            o_irq_vector <= VEC_RX_OFFSET;
        end else if (i_ce) begin
            o_rx_irq_req <= i_rx_irq_enable && (i_silo_alarm_enable
                ? o_silo_alarm_flag : i_rx_done_flag);
            o_tx_irq_req <= i_tx_irq_enable && o_tx_ready_flag;
            if (i_rx_irq_enable && (i_silo_alarm_enable
                    ? o_silo_alarm_flag : i_rx_done_flag)) begin
                o_irq_vector <= VEC_RX_OFFSET;
            end else begin
                o_irq_vector <= VEC_TX_OFFSET;
            end
        end
    end

    // Modem input synchronisers
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ring_meta_reg <= '0;
            ring_reg <= '0;
            carrier_meta_reg <= '0;
            carrier_reg <= '0;
        end else if (i_ce) begin
            ring_meta_reg <= i_ring;
            ring_reg <= ring_meta_reg;
            carrier_meta_reg <= i_carrier;
            carrier_reg <= carrier_meta_reg;
        end
    end

    // Register reads; transmit data register is write-only
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_rdata <= RDATA_RST;
            o_reg_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= RDATA_RST;
                case (i_reg_sel)
                    REG_TX_LINE_CTRL: begin
                        o_reg_rdata[ENABLE_LSB +: LINES] <= line_enable_reg;
                        o_reg_rdata[DTR_LSB +: LINES] <= o_term_ready;
                    end
                    REG_MODEM_STATUS: begin
                        o_reg_rdata[RING_LSB +: LINES] <= ring_reg;
                        o_reg_rdata[CARRIER_LSB +: LINES] <= carrier_reg;
                    end
                    default: begin
                        o_reg_rdata <= RDATA_RST;
                    end
                endcase
            end
        end
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    property p_enable_clear;
        (i_ce && clear_any) |=> line_enable_reg == ENABLE_RST;
    endproperty
    a_enable_clear: assert property (p_enable_clear)
        else $error("line enables survive a clear");

    property p_dtr_keep;
        (i_ce && i_master_clear && !i_bus_init && !ctrl_wr)
            |=> $stable(o_term_ready);
    endproperty
    a_dtr_keep: assert property (p_dtr_keep)
        else $error("terminal ready changed by master clear");

    property p_pick_top;
        (i_ce && !clear_any && state_reg == QLT_SCAN && start)
            |=> o_tx_ready_flag
                && ($past(cand) >> o_tx_line_number) == 4'h1;
    endproperty
    a_pick_top: assert property (p_pick_top)
        else $error("scanner did not select highest line");

    property p_resume;
        (i_ce && o_tx_ready_flag && char_wr) |=> !o_tx_ready_flag;
    endproperty
    a_resume: assert property (p_resume)
        else $error("scanner stayed halted after a character");

    property p_break_space;
        i_ce |=> (o_line_txd & $past(break_reg)) == '0;
    endproperty
    a_break_space: assert property (p_break_space)
        else $error("break line not at space");

    property p_no_rx_irq;
        (i_ce && !i_rx_irq_enable && !i_silo_alarm_enable)
            |=> !o_rx_irq_req;
    endproperty
    a_no_rx_irq: assert property (p_no_rx_irq)
        else $error("receiver interrupt with enables clear");

    property p_done_irq;
        (i_ce && i_rx_irq_enable && !i_silo_alarm_enable && i_rx_done_flag)
            |=> o_rx_irq_req && o_irq_vector == VEC_RX_OFFSET;
    endproperty
    a_done_irq: assert property (p_done_irq)
        else $error("receiver done gave no interrupt");

    property p_alarm_only;
        (i_ce && i_silo_alarm_enable && !o_silo_alarm_flag)
            |=> !o_rx_irq_req;
    endproperty
    a_alarm_only: assert property (p_alarm_only)
        else $error("receiver interrupt without silo alarm");

    property p_alarm_set;
        (i_ce && i_silo_char_in && !i_rx_buffer_access
            && silo_cnt_reg == 5'h0F) |=> o_silo_alarm_flag;
    endproperty
    a_alarm_set: assert property (p_alarm_set)
        else $error("silo alarm missing at sixteen characters");

    property p_tx_irq;
        (i_ce && i_tx_irq_enable && o_tx_ready_flag) |=> o_tx_irq_req;
    endproperty
    a_tx_irq: assert property (p_tx_irq)
        else $error("transmit ready gave no interrupt");

    property p_rx_first;
        (o_rx_irq_req && o_tx_irq_req) |-> o_irq_vector == VEC_RX_OFFSET;
    endproperty
    a_rx_first: assert property (p_rx_first)
        else $error("transmit vector ahead of receiver");

    c_halt: cover property ($rose(o_tx_ready_flag));
    c_alarm: cover property ($rose(o_silo_alarm_flag));
    c_both_irq: cover property (o_rx_irq_req && o_tx_irq_req);
    c_break: cover property (|break_reg && o_tx_ready_flag);
endmodule : qlt_scan

// ===== hdl/qlt_pkg.sv
// Constants and types shared by the four-line transmit scanner block.
// Assumes the includer imports the whole package.
package qlt_pkg;
    localparam int LINES = 4;
    localparam int CHAR_W = 8;
    localparam int BUF_DEPTH = 2;
    // Register select codes on the register port
    localparam logic [1:0] REG_TX_LINE_CTRL = 2'h0;
    localparam logic [1:0] REG_MODEM_STATUS = 2'h1;
    localparam logic [1:0] REG_TX_CHAR_BREAK = 2'h2;
    // Field positions
    localparam int ENABLE_LSB = 0;
    localparam int DTR_LSB = 8;
    localparam int RING_LSB = 0;
    localparam int CARRIER_LSB = 8;
    localparam int CHAR_LSB = 0;
    localparam int BREAK_LSB = 8;
    // Values after reset
    localparam logic [3:0] ENABLE_RST = 4'h0;
    localparam logic [3:0] DTR_RST = 4'h0;
    localparam logic [3:0] BREAK_RST = 4'h0;
    localparam logic [4:0] SILO_CNT_RST = 5'h00;
    localparam logic [15:0] RDATA_RST = 16'h0000;
    localparam logic [1:0] LINE_RST = 2'h0;
    // Silo alarm threshold in characters
    localparam logic [4:0] SILO_ALARM_COUNT = 5'h10;
    // Interrupt vector offsets
    localparam logic [2:0] VEC_RX_OFFSET = 3'h0;
    localparam logic [2:0] VEC_TX_OFFSET = 3'h4;
    // Serial line levels
    localparam logic SPACE_LEVEL = 1'b0;
    localparam logic MARK_LEVEL = 1'b1;

    typedef enum logic [1:0] {
        QLT_SCAN = 2'b01,
        QLT_HALT = 2'b10
    } qlt_scan_type;
endpackage : qlt_pkg

// ===== hdl/qlt_buf.sv
// Small first-in first-out buffer, head word and flags held in flops.
// Assumes one clock, push only while o_in_ready is high.
`timescale 1ns/10ps
module qlt_buf #(
    parameter int WIDTH = 10,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    // Filling side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Draining side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_ZERO = '0;
    localparam logic [CW-1:0] CNT_ONE = CW'(1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic push;
    logic pop;

    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem_reg[0];

    always_comb begin
        count_next = count_reg;
        if (push && !pop) begin
            count_next = count_reg + CNT_ONE;
        end else if (pop && !push) begin
            count_next = count_reg - CNT_ONE;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            count_reg <= CNT_ZERO;
            o_out_valid <= 1'b0;
            o_in_ready <= 1'b1;
        end else if (i_ce) begin
            count_reg <= count_next;
            o_out_valid <= count_next != CNT_ZERO;
            o_in_ready <= count_next != CNT_FULL;
        end
    end

    // Shift toward the head on pop, write at first free slot
    always_ff @(posedge i_clk) begin
        if (i_ce) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (push && (pop ? count_reg - CNT_ONE : count_reg)
                        == CW'(i)) begin
                    mem_reg[i] <= i_in_data;
                end else if (pop && i < DEPTH - 1) begin
                    mem_reg[i] <= mem_reg[i + 1];
                end
            end
        end
    end

    property p_full_refuses;
        @(posedge i_clk) disable iff (i_rst)
        (count_reg == CNT_FULL) |-> !o_in_ready;
    endproperty
    a_full_refuses: assert property (p_full_refuses)
        else $error("buffer ready while full");
    c_buf_full: cover property (@(posedge i_clk) count_reg == CNT_FULL);
endmodule : qlt_buf

// ===== verif/qlt_tx_model.sv
// Four-line transmitter stand-in facing the scanner's character stream.
// Assumes the scanner's clock; stalling is commanded by the bench.
`timescale 1ns/10ps
module qlt_tx_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_stall,
    // Character stream
    input wire logic i_char_valid,
    input wire logic [7:0] i_char_data,
    input wire logic [1:0] i_char_line,
    output logic o_char_ready,
    // Line side
    output logic [3:0] o_empty,
    output logic [3:0] o_txd
);
    logic [3:0] busy_reg [4];
    logic [7:0] shift_reg [4];
    assign o_char_ready = !i_stall;
    // Shifts a character out, lsb first, idling at mark
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int n = 0; n < 4; n++) begin
                busy_reg[n] <= 4'h0;
                shift_reg[n] <= 8'h00;
            end
        end else begin
            for (int n = 0; n < 4; n++) begin
                if (busy_reg[n] != 4'h0) begin
                    busy_reg[n] <= busy_reg[n] - 4'h1;
                    shift_reg[n] <= {1'b1, shift_reg[n][7:1]};
                end
            end
            if (i_char_valid && !i_stall) begin
                busy_reg[i_char_line] <= 4'h9;
                shift_reg[i_char_line] <= i_char_data;
            end
        end
    end
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            o_empty[n] = busy_reg[n] == 4'h0;
            o_txd[n] = o_empty[n] ? 1'b1 : shift_reg[n][0];
        end
    end
endmodule : qlt_tx_model

// ===== verif/tb_top.sv
// Self-checking bench for the scanner block with a transmitter model.
// Assumes a 10 MHz clock; inputs change 1 ns after the rising edge.
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("[ERR] %0t got %h want %h", $time, a, b); \
    end end
module tb_top;
    import qlt_pkg::*;
    logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
    logic [1:0] i_reg_sel = 2'h0, i_reg_be = 2'h0;
    logic i_reg_wr = 1'b0, i_reg_rd = 1'b0;
    logic [15:0] i_reg_wdata = 16'h0000, o_reg_rdata;
    logic i_master_scan_enable = 1'b0, i_tx_irq_enable = 1'b0;
    logic i_rx_irq_enable = 1'b0, i_silo_alarm_enable = 1'b0;
    logic i_master_clear = 1'b0, i_bus_init = 1'b0, i_rx_done_flag = 1'b0;
    logic i_silo_char_in = 1'b0, i_rx_buffer_access = 1'b0;
    logic o_reg_rvalid, o_tx_ready_flag, o_silo_alarm_flag, o_rx_irq_req;
    logic o_tx_irq_req, o_char_valid, i_char_ready;
    logic [1:0] o_tx_line_number, o_char_line;
    logic [2:0] o_irq_vector;
    logic [7:0] o_char_data, d;
    logic [3:0] i_line_tx_empty, i_uart_txd, o_line_txd, o_term_ready;
    logic [3:0] i_ring = 4'h0, i_carrier = 4'h0;
    logic stall = 1'b0, hold = 1'b1;
    logic [9:0] exp_q [$];
    logic [9:0] got;
    int seed = 92, fail_count = 0, comparisons = 0, cyc = 0;

    qlt_scan dut_u (.i_clk, .i_rst, .i_ce, .i_reg_sel, .i_reg_wr, .i_reg_rd,
        .i_reg_be, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
        .i_master_scan_enable, .i_tx_irq_enable, .i_rx_irq_enable,
        .i_silo_alarm_enable, .i_master_clear, .i_bus_init,
        .o_tx_ready_flag, .o_tx_line_number, .o_silo_alarm_flag,
        .i_rx_done_flag, .i_silo_char_in, .i_rx_buffer_access,
        .o_rx_irq_req, .o_tx_irq_req, .o_irq_vector, .i_line_tx_empty,
        .o_char_valid, .o_char_data, .o_char_line, .i_char_ready,
        .i_uart_txd, .o_line_txd, .i_ring, .i_carrier, .o_term_ready);
    qlt_tx_model model_u (.i_clk(i_clk), .i_rst(i_rst), .i_stall(stall),
        .i_char_valid(o_char_valid), .i_char_data(o_char_data),
        .i_char_line(o_char_line), .o_char_ready(i_char_ready),
        .o_empty(i_line_tx_empty), .o_txd(i_uart_txd));

    always #50 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        #1;
        stall = hold | 1'($random(seed) & 1);
    end
    // Each character leaving the buffer must match what was written
    // Sampled mid-cycle, where the handshake is settled
    always @(negedge i_clk) begin
        cyc++;
        if (o_char_valid === 1'b1 && i_char_ready === 1'b1) begin
            got = exp_q.size() ? exp_q.pop_front() : 10'h3FF;
            `CHK({o_char_line, o_char_data}, got)
        end
        if (cyc == 6000) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic tick(int n = 1);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick();
        s = 1'b0;
        tick();
    endtask : pulse
    task automatic wr(logic [1:0] sel, logic [1:0] be, logic [15:0] w);
        i_reg_sel = sel;
        i_reg_be = be;
        i_reg_wdata = w;
        pulse(i_reg_wr);
        tick();
    endtask : wr
    task automatic rd(logic [1:0] sel, logic [15:0] want);
        i_reg_sel = sel;
        i_reg_rd = 1'b1;
        tick();
        i_reg_rd = 1'b0;
        for (int n = 0; n < 3 && o_reg_rvalid !== 1'b1; n++) tick();
        `CHK(o_reg_rvalid, 1'b1)
        `CHK(o_reg_rdata, want)
    endtask : rd
    task automatic wait_rdy;
        for (int n = 0; n < 80 && o_tx_ready_flag !== 1'b1; n++) tick();
        `CHK(o_tx_ready_flag, 1'b1)
    endtask : wait_rdy
    task automatic put(logic [7:0] c, logic [1:0] line);
        exp_q.push_back({line, c});
        wr(REG_TX_CHAR_BREAK, 2'h1, {8'h00, c});
    endtask : put
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up

    initial begin
        tick(20);
        i_rst = 1'b0;
        `CHK(o_line_txd, 4'hF)
        rd(REG_TX_LINE_CTRL, 16'h0000);
        wr(REG_TX_LINE_CTRL, 2'h3, 16'hFFFF);
        rd(REG_TX_LINE_CTRL, 16'h0F0F);
        `CHK(o_term_ready, 4'hF)
        wr(REG_TX_CHAR_BREAK, 2'h2, 16'hFF00);
        `CHK(o_line_txd, 4'h0)
        pulse(i_master_clear);
        rd(REG_TX_LINE_CTRL, 16'h0F00);
        `CHK(o_line_txd, 4'hF)
        wr(REG_TX_LINE_CTRL, 2'h3, 16'hFFFF);
        pulse(i_bus_init);
        rd(REG_TX_LINE_CTRL, 16'h0000);
        `CHK(o_term_ready, 4'h0)
        rd(REG_TX_CHAR_BREAK, 16'h0000);
        // Clock enable low freezes the register file
        i_ce = 1'b0;
        wr(REG_TX_LINE_CTRL, 2'h3, 16'hFFFF);
        i_ce = 1'b1;
        rd(REG_TX_LINE_CTRL, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            i_ring = 4'($random(seed));
            i_carrier = 4'($random(seed));
            tick(3);
            rd(REG_MODEM_STATUS, {4'h0, i_carrier, 4'h0, i_ring});
        end
        wr(REG_TX_LINE_CTRL, 2'h1, 16'h000F);
        i_master_scan_enable = 1'b1;
        i_tx_irq_enable = 1'b1;
        wait_rdy();
        `CHK(o_tx_line_number, 2'h3)
        tick(2);
        `CHK(o_tx_irq_req, 1'b1)
        `CHK(o_irq_vector, VEC_TX_OFFSET)
        put(8'hA5, 2'h3);
        wait_rdy();
        `CHK(o_tx_line_number, 2'h2)
        put(8'h3C, 2'h2);
        tick(10);
        `CHK(o_tx_ready_flag, 1'b0)
        hold = 1'b0;
        tick(40);
        wait_rdy();
        wr(REG_TX_LINE_CTRL, 2'h1, 16'h0001);
        wait_rdy();
        `CHK(o_tx_line_number, 2'h0)
        wr(REG_TX_CHAR_BREAK, 2'h2, 16'h0F00);
        wr(REG_TX_LINE_CTRL, 2'h1, 16'h000F);
        for (int k = 0; k < 40; k++) begin
            wait_rdy();
            d = 8'($random(seed));
            put(d, o_tx_line_number);
        end
        tick(60);
        `CHK(exp_q.size(), 0)
        `CHK(o_line_txd, 4'h0)
        wait_rdy();
        i_rx_done_flag = 1'b1;
        tick(3);
        `CHK(o_rx_irq_req, 1'b0)
        i_rx_irq_enable = 1'b1;
        tick(3);
        `CHK(o_rx_irq_req, 1'b1)
        `CHK(o_irq_vector, VEC_RX_OFFSET)
        i_silo_alarm_enable = 1'b1;
        pulse(i_rx_buffer_access);
        tick(2);
        `CHK(o_rx_irq_req, 1'b0)
        i_silo_char_in = 1'b1;
        tick(15);
        i_silo_char_in = 1'b0;
        tick(3);
        `CHK(o_silo_alarm_flag, 1'b0)
        pulse(i_silo_char_in);
        tick(2);
        `CHK(o_silo_alarm_flag, 1'b1)
        `CHK(o_rx_irq_req, 1'b1)
        pulse(i_rx_buffer_access);
        tick(2);
        `CHK(o_silo_alarm_flag, 1'b0)
        wrap_up();
    end
endmodule : tb_top
